// *** drive_run_shutoff_logic.sv ***
// Run command decode and output shutoff decision with APB control registers
//
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps

// Functional notes
// (R1) Active shutoff cuts output at once, no ramp
// (R2) Shutoff routed by assigning code 24 to terminal
// (R3) No start while shutoff input is active
// (R4) Start removal decelerates; shutoff makes motor coast
// (R5) Polarity 0 NO, 2 NC, 4 external NC
// (R6) Operation enabled only for the listed states
// (R7) External shutoff acts in every operation mode
// (R8) Second-function input selects second parameter set
// (R9) All second-set parameters switch together
// (R10) Stop 0-100 s: coast after that delay
// (R11) Stop 1000-1100 s: coast after value minus 1000
// (R12) Stop 9999: two-wire start, decelerate on removal
// (R13) 8888 or 1000-1100: run plus direction inputs
// (R14) Two-wire: one input runs, none or both stop
// (R15) Shutoff acts within 2 ms, others 20 ms
// (R16) Function on several terminals combines by OR
// (R17) Inputs sampled synchronously, shutoff decided before run
module drive_run_shutoff_logic
  import drive_run_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = SECOND_CYCLES
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                ce,
  input  wire logic [TERM_N-1:0]   termIn,
  input  wire logic                decelDone,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  output logic                     outputOn,
  output logic                     runReverse,
  output logic                     decelerating,
  output logic                     coastStop,
  output logic                     secondSet,
  output logic                     shutoffActive
);

  typedef struct packed {
    logic [TERM_N-1:0]        termMeta;
    logic [TERM_N-1:0]        termSync;
    logic [2:0]               polarity;
    logic [STOP_W-1:0]        stopSel;
    logic                     commShutoff;
    logic [TERM_N*CODE_W-1:0] fnAssign;
    run_state_t               state;
    logic [6:0]               timer;
    logic [TICK_W-1:0]        tick;
    logic                     outOn;
    logic                     reverse;
    logic                     decel;
    logic                     coast;
    logic                     second;
    logic                     shutoff;
    logic [31:0]              rdata;
    logic                     ready;
    logic                     slverr;
  } state_t;

  state_t cur;
  state_t next_cur;

  // OR of every synchronised terminal that carries the given function code
  function automatic logic anyAssigned(input logic [TERM_N*CODE_W-1:0] asg,
                                       input logic [TERM_N-1:0] term,
                                       input logic [CODE_W-1:0] code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < TERM_N; i++) begin
      if (asg[i*CODE_W +: CODE_W] == code && term[i]) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  // Operation permitted for the external and communication shutoff levels
  function automatic logic shutoffClear(input logic [2:0] pol,
                                        input logic ext,
                                        input logic comm);
    logic ok;
    unique case (pol)
      POL_NC_BOTH: ok = ext && comm;
      POL_NC_EXT:  ok = ext && !comm;
      // Codes other than 2 and 4 act as normally open
      default:     ok = !ext && !comm;
    endcase
    return ok;
  endfunction

  // True when a setting lies inside an inclusive range
  function automatic logic inRange(input logic [STOP_W-1:0] v,
                                   input logic [STOP_W-1:0] lo,
                                   input logic [STOP_W-1:0] hi);
    return v >= lo && v <= hi;
  endfunction

  // Terminal code words sit one aligned word apart
  function automatic logic isAssignAddr(input logic [ADDR_W-1:0] a);
    return a >= OFS_ASSIGN0 && a <= OFS_ASSIGN4 && a[1:0] == 2'h0;
  endfunction

  // Terminal number for an assignment word address
  function automatic int assignIndex(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] ofs;
    ofs = a - OFS_ASSIGN0;
    return int'(ofs >> 2);
  endfunction

  // Register read decode; bit 32 flags an unmapped address
  function automatic logic [32:0] readReg(input state_t s, input logic [ADDR_W-1:0] a);
    logic [32:0] r;
    int          idx;
    r   = '0;
    idx = 0;
    if (a == OFS_POLARITY) begin
      r[2:0] = s.polarity;
    end else if (a == OFS_STOPSEL) begin
      r[STOP_W-1:0] = s.stopSel;
    end else if (a == OFS_COMM) begin
      r[COMM_SHUTOFF_BIT] = s.commShutoff;
    end else if (a == OFS_STATUS) begin
      r[ST_TERM_LSB +: TERM_N] = s.termSync;
      r[ST_SHUTOFF]            = s.shutoff;
      r[ST_OUT_ON]             = s.outOn;
      r[ST_REVERSE]            = s.reverse;
      r[ST_DECEL]              = s.decel;
      r[ST_SECOND]             = s.second;
      r[ST_TIMER_LSB +: 7]     = s.timer;
    end else if (isAssignAddr(a)) begin
      idx = assignIndex(a);
      r[CODE_W-1:0] = s.fnAssign[idx*CODE_W +: CODE_W];
    end else begin
      r[32] = 1'b1;
    end
    return r;
  endfunction

  logic                extShutoff;
  logic                fwdIn;
  logic                revIn;
  logic                threeWire;
  logic                timedStop;
  logic [6:0]          stopSecs;
  logic                runCmd;
  logic                runRev;
  logic                allowRun;
  logic                wrEn;
  logic [32:0]         rd;
  logic                setupCycle;

  always_comb begin
    next_cur = cur;

    // Two-stage synchroniser on the terminal pins
    next_cur.termMeta = termIn;
    next_cur.termSync = cur.termMeta;

    // Function routing from terminal assignment
    extShutoff = anyAssigned(cur.fnAssign, cur.termSync, FN_SHUTOFF);   // see (R2) (R16)
    fwdIn      = anyAssigned(cur.fnAssign, cur.termSync, FN_FWD_START); // see (R16)
    revIn      = anyAssigned(cur.fnAssign, cur.termSync, FN_REV_START); // see (R16)
    next_cur.second = anyAssigned(cur.fnAssign, cur.termSync, FN_SECOND_SET); // see (R8) (R9)

    // Shutoff decision from both sources, independent of operation mode
    allowRun = shutoffClear(cur.polarity, extShutoff, cur.commShutoff); // see (R5) (R6) (R7)
    next_cur.shutoff = !allowRun;

    // Stop selection decoding
    threeWire = inRange(cur.stopSel, STOP_3W_MIN, STOP_3W_MAX)
                || cur.stopSel == STOP_3W_DECEL;                         // see (R13)
    timedStop = cur.stopSel <= STOP_TIMED_MAX
                || inRange(cur.stopSel, STOP_3W_MIN, STOP_3W_MAX);      // see (R10) (R11)
    if (cur.stopSel <= STOP_TIMED_MAX) begin
      stopSecs = cur.stopSel[6:0];                                       // see (R10)
    end else begin
      stopSecs = 7'(cur.stopSel - STOP_3W_MIN);                          // see (R11)
    end

    // Start decoding: run plus direction, or forward and reverse starts
    if (threeWire) begin
      runCmd = fwdIn;                                                    // see (R13)
      runRev = revIn;
    end else begin
      runCmd = fwdIn ^ revIn;                                            // see (R12) (R14)
      runRev = revIn;
    end

    // Run state machine; the shutoff check comes first
    next_cur.coast = 1'b0;
    if (!allowRun) begin                                                 // see (R17)
      next_cur.state = ST_IDLE;                                          // see (R1) (R3) (R15)
      next_cur.coast = cur.state != ST_IDLE;                             // see (R4)
      next_cur.timer = '0;
      next_cur.tick  = '0;
    end else begin
      unique case (cur.state)
        ST_IDLE: begin
          if (runCmd) begin
            next_cur.state   = ST_RUN;
            next_cur.reverse = runRev;
          end
        end
        ST_RUN: begin
          if (runCmd) begin
            next_cur.reverse = runRev;
          end else if (timedStop && stopSecs == 7'h00) begin
            next_cur.state = ST_IDLE;                                    // see (R10) (R11)
            next_cur.coast = 1'b1;
          end else begin
            next_cur.state = ST_DECEL_STOP;                              // see (R4) (R14)
            // Only timed stops show a countdown in the status word
            next_cur.timer = timedStop ? stopSecs : 7'h00;
            next_cur.tick  = '0;
          end
        end
        ST_DECEL_STOP: begin
          if (runCmd) begin
            next_cur.state   = ST_RUN;
            next_cur.reverse = runRev;
            next_cur.timer   = '0;
          end else if (timedStop) begin
            // One tick per second of delay; coast when it runs out
            if (cur.tick == TICK_W'(SEC_CYCLES - 1)) begin
              next_cur.tick  = '0;
              next_cur.timer = cur.timer - 7'h01;
              if (cur.timer == 7'h01) begin
                next_cur.state = ST_IDLE;                                // see (R10) (R11)
                next_cur.coast = 1'b1;
              end
            end else begin
              next_cur.tick = cur.tick + TICK_W'(1);
            end
          end else if (decelDone) begin
            next_cur.state = ST_IDLE;                                    // see (R12) (R13)
          end
        end
        // Unused state code falls back to idle
        default: begin
          next_cur.state = ST_IDLE;
        end
      endcase
    end
    next_cur.outOn = next_cur.state != ST_IDLE;
    next_cur.decel = next_cur.state == ST_DECEL_STOP;

    // APB slave: answer one cycle after setup, write on the accepting edge
    // Setup cycle not yet answered
    setupCycle = psel && !penable && !cur.ready;
    wrEn = psel && penable && cur.ready && pwrite;
    rd   = readReg(cur, paddr);
    next_cur.ready  = setupCycle;
    next_cur.slverr = setupCycle && rd[32];
    if (setupCycle) begin
      next_cur.rdata = pwrite ? 32'h0 : rd[31:0];
    end else if (!(psel && penable)) begin
      next_cur.rdata = '0;
    end
    // Words flagged at setup take no write
    if (wrEn && !cur.slverr) begin
      if (paddr == OFS_POLARITY) begin
        next_cur.polarity = pwdata[2:0];
      end else if (paddr == OFS_STOPSEL) begin
        next_cur.stopSel = pwdata[STOP_W-1:0];
      end else if (paddr == OFS_COMM) begin
        next_cur.commShutoff = pwdata[COMM_SHUTOFF_BIT];
      end else if (isAssignAddr(paddr)) begin
        next_cur.fnAssign[assignIndex(paddr)*CODE_W +: CODE_W] = pwdata[CODE_W-1:0]; // see (R2)
      end
    end
  end

  // All state registered here; clock enable low freezes everything
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur          <= '0;
      cur.polarity <= POL_RESET;
      cur.stopSel  <= STOP_RESET;
      cur.fnAssign <= ASSIGN_RESET;
      cur.state    <= ST_IDLE;
    end else if (ce) begin
      cur <= next_cur;
    end
  end

  assign prdata        = cur.rdata;
  assign pready        = cur.ready;
  assign pslverr       = cur.slverr;
  assign outputOn      = cur.outOn;
  assign runReverse    = cur.reverse;
  assign decelerating  = cur.decel;
  assign coastStop     = cur.coast;
  assign secondSet     = cur.second;
  assign shutoffActive = cur.shutoff;

endmodule

// *** drive_run_pkg.sv ***
// Constants, register map and types for the drive run and shutoff logic
package drive_run_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ           = 20_000_000;
  localparam int unsigned CLK_PERIOD_NS    = 1_000_000_000 / CLK_HZ;
  localparam int unsigned SECOND_NS        = 1_000_000_000;
  localparam int unsigned SECOND_CYCLES    = SECOND_NS / CLK_PERIOD_NS;
  localparam int unsigned SHUTOFF_RESP_NS  = 2_000_000;
  localparam int unsigned SHUTOFF_RESP_CYC = SHUTOFF_RESP_NS / CLK_PERIOD_NS;
  localparam int unsigned OTHER_RESP_NS    = 20_000_000;
  localparam int unsigned OTHER_RESP_CYC   = OTHER_RESP_NS / CLK_PERIOD_NS;
  localparam int          TICK_W           = 25;

  // Input terminals and function codes
  localparam int          TERM_N        = 5;
  localparam int          CODE_W        = 7;
  localparam logic [6:0]  FN_SECOND_SET = 7'h03;
  localparam logic [6:0]  FN_SHUTOFF    = 7'h18;
  localparam logic [6:0]  FN_FWD_START  = 7'h3c;
  localparam logic [6:0]  FN_REV_START  = 7'h3d;
  localparam logic [6:0]  FN_LOW_SPEED  = 7'h00;
  localparam logic [6:0]  FN_MID_SPEED  = 7'h01;
  localparam logic [6:0]  FN_HIGH_SPEED = 7'h02;

  // Shutoff polarity setting
  localparam logic [2:0]  POL_NO_BOTH   = 3'h0;
  localparam logic [2:0]  POL_NC_BOTH   = 3'h2;
  localparam logic [2:0]  POL_NC_EXT    = 3'h4;
  localparam logic [2:0]  POL_RESET     = POL_NO_BOTH;

  // Stop selection setting
  localparam int          STOP_W        = 14;
  localparam logic [13:0] STOP_TIMED_MAX = 14'h0064;
  localparam logic [13:0] STOP_3W_MIN   = 14'h03e8;
  localparam logic [13:0] STOP_3W_MAX   = 14'h044c;
  localparam logic [13:0] STOP_3W_DECEL = 14'h22b8;
  localparam logic [13:0] STOP_2W_DECEL = 14'h270f;
  localparam logic [13:0] STOP_RESET    = STOP_2W_DECEL;

  // APB register map (byte addresses)
  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  OFS_POLARITY  = 8'h00;
  localparam logic [7:0]  OFS_STOPSEL   = 8'h04;
  localparam logic [7:0]  OFS_COMM      = 8'h08;
  localparam logic [7:0]  OFS_STATUS    = 8'h0c;
  localparam logic [7:0]  OFS_ASSIGN0   = 8'h10;
  localparam logic [7:0]  OFS_ASSIGN4   = 8'h20;
  localparam int          COMM_SHUTOFF_BIT = 0;

  // Status register field positions
  localparam int          ST_TERM_LSB   = 0;
  localparam int          ST_SHUTOFF    = 8;
  localparam int          ST_OUT_ON     = 9;
  localparam int          ST_REVERSE    = 10;
  localparam int          ST_DECEL      = 11;
  localparam int          ST_SECOND     = 12;
  localparam int          ST_TIMER_LSB  = 16;

  // Reset terminal assignment: forward, reverse, low, middle, high speed
  localparam logic [34:0] ASSIGN_RESET  = {FN_HIGH_SPEED, FN_MID_SPEED, FN_LOW_SPEED,
                                           FN_REV_START, FN_FWD_START};

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RUN,
    ST_DECEL_STOP
  } run_state_t;

endpackage

// *** drive_run_shutoff_assertions.sv ***
// Port-level assertions for the drive run and shutoff logic
`timescale 1ns/10ps
module drive_run_shutoff_assertions (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic outputOn,
  input wire logic decelerating,
  input wire logic coastStop,
  input wire logic shutoffActive
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence apbSetup;
    psel && !penable && ce;
  endsequence
  sequence shutWhileOn;
    $rose(shutoffActive) && $past(outputOn);
  endsequence
  chk_setup_answered: assert property (apbSetup |=> pready)
    else $error("setup not answered");
  chk_ready_single: assert property (pready |=> !pready)
    else $error("pready too long");
  chk_error_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr alone");
  chk_shutoff_blocks: assert property (shutoffActive |-> !outputOn)
    else $error("output on while shut off");
  chk_shutoff_coasts: assert property (shutWhileOn |-> coastStop)
    else $error("shutoff without coast");
  chk_coast_pulse: assert property (coastStop |=> !coastStop)
    else $error("coast pulse too long");
  chk_coast_cuts: assert property (coastStop |-> !outputOn && !decelerating)
    else $error("coast with output on");
  chk_decel_output: assert property (decelerating |-> outputOn)
    else $error("decelerating with output off");
endmodule
bind drive_run_shutoff_logic drive_run_shutoff_assertions i_chk (
  .clk(clk), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .outputOn(outputOn), .decelerating(decelerating),
  .coastStop(coastStop), .shutoffActive(shutoffActive));

// *** field_panel.sv ***
// Terminal panel and motor ramp model facing the drive logic
`timescale 1ns/10ps
module field_panel (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [4:0] switches,
  input  wire logic       decelerating,
  output logic      [4:0] termIn,
  output logic            decelDone
);
  logic [5:0] ramp;
  logic       slow;
  // Contacts follow the switches a clock later; every second ramp is a long one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      termIn <= 5'h00;
      ramp   <= 6'h00;
      slow   <= 1'b0;
    end else begin
      termIn <= switches;
      ramp   <= decelerating ? ramp + 6'h01 : 6'h00;
      slow   <= slow ^ (ramp != 6'h00 && !decelerating);
    end
  end
  assign decelDone = decelerating && ramp >= (slow ? 6'h30 : 6'h03);
endmodule

// *** drive_run_shutoff_logic_tb_top.sv ***
// Self-checking bench for the drive run and shutoff logic
`timescale 1ns/10ps
module drive_run_shutoff_logic_tb_top
  import drive_run_pkg::*;
  ();
  localparam int SEC = 4;
  logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [4:0]  sw = 5'h00, termIn;
  logic        pready, pslverr, decelDone, outputOn, runReverse;
  logic        decelerating, coastStop, secondSet, shutoffActive;
  int          fails = 0, samples_checked = 0, n;
  int          secs [3] = '{2, 1, 0};
  logic [13:0] stops [3] = '{14'h0002, 14'h03e9, 14'h0000};
  always #(CLK_PERIOD_NS / 2) clk = ~clk;
  drive_run_shutoff_logic #(.SEC_CYCLES(SEC)) i_drive_run_shutoff_logic (
    .clk(clk), .rst_n(rst_n), .ce(1'b1), .termIn(termIn), .decelDone(decelDone),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .outputOn(outputOn),
    .runReverse(runReverse), .decelerating(decelerating), .coastStop(coastStop),
    .secondSet(secondSet), .shutoffActive(shutoffActive));
  field_panel i_field_panel (.clk(clk), .rst_n(rst_n), .switches(sw),
    .decelerating(decelerating), .termIn(termIn), .decelDone(decelDone));
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] got);
    samples_checked++;
    if (got !== x) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, x, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] x = 32'h0, input logic xe = 1'b0);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk);
    while (pready !== 1'b1);
    chk("pslverr", {31'h0, xe}, {31'h0, pslverr});
    if (!w) chk("prdata", x, prdata);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // Terminal outputs settle three edges after the panel contacts move
  task automatic step(input logic [4:0] v, input string nm, ref logic sig, input logic x);
    @(posedge clk);
    sw <= v;
    repeat (5) @(negedge clk);
    chk(nm, x, sig);
  endtask
  task automatic waitSig(ref logic sig, input logic x);
    n = 0;
    while (sig !== x && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk("wait", x, sig);
  endtask
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clk);
    fails++;
    print_verdict();
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, OFS_STOPSEL, 32'h0, {18'h0, STOP_RESET});
    apb(1'b0, 8'h40, 32'h0, 32'h0, 1'b1);
    apb(1'b1, OFS_ASSIGN0 + 8'h08, {25'h0, FN_SHUTOFF});
    apb(1'b1, OFS_ASSIGN0 + 8'h0c, {25'h0, FN_SECOND_SET});
    apb(1'b1, OFS_ASSIGN4, {25'h0, FN_SECOND_SET});
    apb(1'b0, OFS_ASSIGN0 + 8'h08, 32'h0, {25'h0, FN_SHUTOFF});
    $display("registers done");
    step(5'h01, "fwd run", outputOn, 1'b1);
    apb(1'b0, OFS_STATUS, 32'h0, (32'h1 << ST_OUT_ON) | 32'h1);
    step(5'h03, "both stop", decelerating, 1'b1);
    waitSig(outputOn, 1'b0);
    step(5'h0a, "rev dir", runReverse, 1'b1);
    chk("second", 1'b1, secondSet);
    step(5'h12, "second or", secondSet, 1'b1);
    step(5'h00, "stop decel", decelerating, 1'b1);
    waitSig(outputOn, 1'b0);
    $display("two-wire done");
    for (int p = 0; p < 3; p++) begin
      apb(1'b1, OFS_POLARITY, {29'h0, 3'(2 * p)});
      for (int c = 0; c < 4; c++) begin
        apb(1'b1, OFS_COMM, {31'h0, c[0]});
        step({2'h0, c[1], 2'h1}, "shutoff", shutoffActive, c != (4 - p) % 4);
        chk("enabled", c == (4 - p) % 4, outputOn);
      end
    end
    apb(1'b1, OFS_COMM, 32'h0);
    apb(1'b1, OFS_POLARITY, 32'h0);
    apb(1'b1, OFS_STOPSEL, {18'h0, STOP_3W_DECEL});
    $display("polarity done");
    step(5'h03, "3w run", runReverse, 1'b1);
    step(5'h02, "3w stop", decelerating, 1'b1);
    step(5'h07, "3w shutoff", outputOn, 1'b0);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, OFS_STOPSEL, {18'h0, stops[i]});
      step(5'h01, "timed run", outputOn, 1'b1);
      @(posedge clk);
      sw <= 5'h00;
      waitSig(coastStop, 1'b1);
      chk("coast delay", 1'b1, (n - SEC * secs[i]) inside {[4:6]});
    end
    $display("stop modes done");
    print_verdict();
  end
endmodule
